// file: design/nv_access_control.sv
/*
 Access control for a 512-byte nonvolatile data store: address, buffer and control registers,
 timed write unlock, self-timed write busy, read strobe, ready interrupt and CPU stall.
 Assumes the CPU presents one register access per cycle and honours the stall output;
 the write timer counts calibrated RC oscillator ticks delivered as a one-cycle pulse.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - 512 bytes addressed linearly by address register bits 8 to 0.
// - Address bits 15..9 and control bits 7..4 read as zero.
// - Buffer register feeds write data and receives read data.
// - Ready interrupt is a level while busy clear, enable and global set.
// - Unlock bit self-clears four cycles after set; strobe inside starts write.
// - Write strobe with unlock clear does nothing.
// - No write starts while flash self-programming is active.
// - Write strobe stays set while writing, cleared by hardware when done.
// - Launching a write stalls the CPU for two cycles.
// - Each read stalls the CPU for four cycles.
// - Read strobe fetches the addressed byte into the buffer at once.
// - During a write, reads are ignored and the address is frozen.
// - Write lasts 67584 calibrated oscillator ticks.
module nv_access_control #(
	parameter int WRITE_TICKS = nv_access_pkg::WRITE_RC_CYCLES
) (
	input  wire logic                  clock,        // CPU clock, 25 MHz
	input  wire logic                  nrst,         // Async reset, active low
	input  wire logic                  ce,           // Clock enable
	input  wire nv_access_pkg::io_req_t ioReq,       // Register access request
	input  wire logic                  rcTick,       // Calibrated oscillator tick pulse
	input  wire logic                  globalIrqEn,  // Global interrupt bit of status word
	input  wire logic                  selfProgBusy, // Self-program enable active
	output      logic [7:0]            ioRdata,      // Registered read data
	output      logic                  readyIrq,     // Ready interrupt level
	output      logic                  cpuStall,     // Halt the CPU
	output      logic                  writeBusy     // Write in progress
);
	import nv_access_pkg::*;

	logic [ADDR_BITS-1:0] nvAddress_reg;
	logic [7:0]           nvByteBuffer_reg;
	logic                 irqEnable_reg;
	logic                 unlock_reg;
	logic [2:0]           unlockCnt_reg;
	nv_state_t            state_reg;
	logic [16:0]          tickCnt_reg;
	logic [2:0]           stallCnt_reg;
	logic [7:0]           storeRdata;
	logic                 ctlWrite;
	logic                 startWrite;
	logic                 startRead;
	logic                 writeDone;
	logic                 busy;

	assign busy     = (state_reg == NV_WRITING);
	assign ctlWrite = ioReq.wr && (ioReq.sel == SEL_CONTROL);
	// Strobe only counts with a live unlock, idle engine and idle flash programming
	assign startWrite = ctlWrite && ioReq.data[BIT_WRITE] && unlock_reg
		&& !busy && !selfProgBusy;
	assign startRead  = ctlWrite && ioReq.data[BIT_READ] && !busy;
	assign writeDone  = busy && rcTick && (tickCnt_reg == 17'(WRITE_TICKS - 1));

	nv_byte_store #(
		.AW(ADDR_BITS),
		.DW(8)
	) u_store (
		.clock(clock),
		.ce(ce),
		.we(writeDone),
		.addr(nvAddress_reg),
		.wdata(nvByteBuffer_reg),
		.rdata(storeRdata)
	);

	// Address register; no reset since its reset value is undefined to software
	always_ff @(posedge clock) begin
		if (ce && ioReq.wr && !busy) begin
			if (ioReq.sel == SEL_ADDR_LOW) begin
				nvAddress_reg[7:0] <= ioReq.data;
			end else if (ioReq.sel == SEL_ADDR_HIGH) begin
				nvAddress_reg[ADDR_BITS-1] <= ioReq.data[0];
			end
		end
	end

	// Buffer register: CPU writes, read strobe loads fetched byte
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			nvByteBuffer_reg <= 8'h00;
		end else if (ce) begin
			if (startRead) begin
				nvByteBuffer_reg <= storeRdata;
			end else if (ioReq.wr && ioReq.sel == SEL_BUFFER) begin
				nvByteBuffer_reg <= ioReq.data;
			end
		end
	end

	// Interrupt enable bit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irqEnable_reg <= 1'b0;
		end else if (ce && ctlWrite) begin
			irqEnable_reg <= ioReq.data[BIT_IRQEN];
		end
	end

	// Unlock window: a fresh set reloads four cycles; other writes leave it running
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			unlock_reg    <= 1'b0;
			unlockCnt_reg <= 3'h0;
		end else if (ce) begin
			if (ctlWrite && ioReq.data[BIT_UNLOCK] && !ioReq.data[BIT_WRITE]) begin
				unlock_reg    <= 1'b1;
				unlockCnt_reg <= UNLOCK_LOAD;
			end else if (unlock_reg) begin
				if (unlockCnt_reg == 3'h1) begin
					unlock_reg <= 1'b0;
				end
				unlockCnt_reg <= unlockCnt_reg - 3'h1;
			end
		end
	end

	// Write engine: counts oscillator ticks, busy clears itself at the end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg   <= NV_IDLE;
			tickCnt_reg <= 17'h00000;
		end else if (ce) begin
			unique case (state_reg)
				NV_IDLE: begin
					if (startWrite) begin
						state_reg   <= NV_WRITING;
						tickCnt_reg <= 17'h00000;
					end
				end
				NV_WRITING: begin
					if (writeDone) begin
						state_reg <= NV_IDLE;
					end else if (rcTick) begin
						tickCnt_reg <= tickCnt_reg + 17'h00001;
					end
				end
			endcase
		end
	end

	// CPU stall: two cycles after a write launch, four after a read
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stallCnt_reg <= 3'h0;
			cpuStall     <= 1'b0;
		end else if (ce) begin
			if (startWrite) begin
				stallCnt_reg <= STALL_WR - 3'h1;
				cpuStall     <= 1'b1;
			end else if (startRead) begin
				stallCnt_reg <= STALL_RD - 3'h1;
				cpuStall     <= 1'b1;
			end else if (stallCnt_reg != 3'h0) begin
				stallCnt_reg <= stallCnt_reg - 3'h1;
				cpuStall     <= 1'b1;
			end else begin
				cpuStall <= 1'b0;
			end
		end
	end

	// Outputs: read data, busy and level interrupt all registered
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ioRdata   <= 8'h00;
			readyIrq  <= 1'b0;
			writeBusy <= 1'b0;
		end else if (ce) begin
			writeBusy <= busy || startWrite;
			readyIrq  <= irqEnable_reg && globalIrqEn
				&& !(busy || startWrite) && !(ctlWrite && !ioReq.data[BIT_IRQEN]);
			if (ioReq.rd) begin
				unique case (ioReq.sel)
					SEL_ADDR_LOW:  ioRdata <= nvAddress_reg[7:0];
					SEL_ADDR_HIGH: ioRdata <= {7'h00, nvAddress_reg[ADDR_BITS-1]};
					SEL_BUFFER:    ioRdata <= nvByteBuffer_reg;
					SEL_CONTROL:   ioRdata <= {4'h0, irqEnable_reg, unlock_reg,
						busy, 1'b0};
				endcase
			end
		end
	end

	// Unlock never outlives its window
	a_unlock_expiry: assert property (@(posedge clock) disable iff (!nrst)
		$rose(unlock_reg) ##0 (ce && !(ctlWrite && ioReq.data[BIT_UNLOCK]))[*4]
		|=> !unlock_reg)
		else $error("unlock bit outlived its window");

	// A strobe without unlock never starts a write
	a_no_unlock_write: assert property (@(posedge clock) disable iff (!nrst)
		ce && ctlWrite && ioReq.data[BIT_WRITE] && !unlock_reg && !busy |=> !busy)
		else $error("write started without unlock");

	// Flash programming blocks writes
	a_flash_blocks: assert property (@(posedge clock) disable iff (!nrst)
		ce && !busy && selfProgBusy |=> !busy)
		else $error("write started during flash programming");

	// Launch stalls exactly two cycles
	a_write_stall: assert property (@(posedge clock) disable iff (!nrst)
		ce && startWrite ##1 ce ##1 ce
		|-> $past(cpuStall) && cpuStall ##1 !cpuStall)
		else $error("write stall length wrong");

	// Read stalls four cycles then releases
	a_read_stall: assert property (@(posedge clock) disable iff (!nrst)
		ce && startRead ##1 (ce && !ctlWrite) [*4] |=> !cpuStall)
		else $error("read stall did not release");

	// Read fetches stored byte into the buffer
	a_read_fetch: assert property (@(posedge clock) disable iff (!nrst)
		ce && startRead |=> nvByteBuffer_reg == $past(storeRdata))
		else $error("read fetch mismatch");

	// Address frozen while writing
	a_addr_frozen: assert property (@(posedge clock) disable iff (!nrst)
		busy && $past(busy) |-> $stable(nvAddress_reg))
		else $error("address changed during write");

	// Interrupt level off whenever the busy output is set
	a_irq_level: assert property (@(posedge clock) disable iff (!nrst)
		writeBusy |-> !readyIrq)
		else $error("ready interrupt while busy");

	// Strobe during a write does not restart the timer
	a_no_restart: assert property (@(posedge clock) disable iff (!nrst)
		ce && busy && !rcTick && !writeDone |=> tickCnt_reg == $past(tickCnt_reg))
		else $error("write timer restarted");

	// Arming the unlock opens the window from the next cycle
	a_unlock_arm: assert property (@(posedge clock) disable iff (!nrst)
		ce && ctlWrite && ioReq.data[BIT_UNLOCK] && !ioReq.data[BIT_WRITE]
		|=> unlock_reg)
		else $error("unlock bit did not arm");

	// Enabled, globally allowed and idle means the level is raised
	a_irq_assert: assert property (@(posedge clock) disable iff (!nrst)
		ce && irqEnable_reg && globalIrqEn && !busy && !ctlWrite |=> readyIrq)
		else $error("ready interrupt missing");

	// Global interrupt bit low always masks the level
	a_irq_gated: assert property (@(posedge clock) disable iff (!nrst)
		ce && !globalIrqEn |=> !readyIrq)
		else $error("ready interrupt not masked");

	// Busy holds until the final tick
	a_busy_holds: assert property (@(posedge clock) disable iff (!nrst)
		ce && busy && !writeDone |=> busy && writeBusy)
		else $error("busy dropped early");

	// Busy output clears one cycle after the final tick
	a_busy_clears: assert property (@(posedge clock) disable iff (!nrst)
		ce && writeDone ##1 (ce && !startWrite) |=> !writeBusy)
		else $error("busy output stuck after write");

	// Status read shows the engine state in the strobe bit
	a_busy_readback: assert property (@(posedge clock) disable iff (!nrst)
		ce && ioReq.rd && ioReq.sel == SEL_CONTROL |=> ioRdata[BIT_WRITE] == $past(busy))
		else $error("strobe bit does not show busy");

	// Reserved control bits and the read strobe read back as zero
	a_reserved_ctl: assert property (@(posedge clock) disable iff (!nrst)
		ce && ioReq.rd && ioReq.sel == SEL_CONTROL
		|=> (ioRdata >> (BIT_IRQEN + 1)) == 8'h00 && !ioRdata[BIT_READ])
		else $error("reserved control bits not zero");

	// Only address bit 8 can show in the high byte
	a_reserved_addr: assert property (@(posedge clock) disable iff (!nrst)
		ce && ioReq.rd && ioReq.sel == SEL_ADDR_HIGH |=> ioRdata <= 8'h01)
		else $error("reserved address bits not zero");

	// Low address write lands when idle
	a_addr_load: assert property (@(posedge clock) disable iff (!nrst)
		ce && ioReq.wr && ioReq.sel == SEL_ADDR_LOW && !busy
		|=> nvAddress_reg[7:0] == $past(ioReq.data))
		else $error("low address byte not loaded");

	// Tick count never passes the write length
	a_tick_range: assert property (@(posedge clock) disable iff (!nrst)
		busy |-> tickCnt_reg < 17'(WRITE_TICKS))
		else $error("write timer overran");

	// Stall never starts on its own
	a_stall_idle: assert property (@(posedge clock) disable iff (!nrst)
		ce && !cpuStall && !startRead && !startWrite |=> !cpuStall)
		else $error("stall raised without an access");

	// The final tick commits the buffer byte to the addressed location
	a_buffer_commit: assert property (@(posedge clock) disable iff (!nrst)
		ce && writeDone |=> storeRdata == $past(nvByteBuffer_reg))
		else $error("stored byte differs from buffer");
endmodule

// file: design/nv_access_pkg.sv
/*
 Shared constants and carriers for the byte-wide nonvolatile store access block.
 Assumes a single CPU clock domain and an I/O-space register port driven by the CPU core.
*/
package nv_access_pkg;
	// Register selects on the I/O port
	localparam logic [1:0] SEL_ADDR_LOW   = 2'h0;
	localparam logic [1:0] SEL_ADDR_HIGH  = 2'h1;
	localparam logic [1:0] SEL_BUFFER     = 2'h2;
	localparam logic [1:0] SEL_CONTROL    = 2'h3;
	// Control register bit positions
	localparam int BIT_READ   = 0;
	localparam int BIT_WRITE  = 1;
	localparam int BIT_UNLOCK = 2;
	localparam int BIT_IRQEN  = 3;
	// Geometry
	localparam int ADDR_BITS  = 9;
	localparam int DEPTH      = 512;
	// Timing
	localparam int UNLOCK_CYCLES    = 4;
	localparam int WRITE_STALL      = 2;
	localparam int READ_STALL       = 4;
	localparam int WRITE_RC_CYCLES  = 67584;
	localparam logic [2:0] UNLOCK_LOAD = 3'h4;
	localparam logic [2:0] STALL_WR    = 3'h2;
	localparam logic [2:0] STALL_RD    = 3'h4;
	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] sel;
		logic [7:0] data;
	} io_req_t;
	typedef enum logic [0:0] {NV_IDLE, NV_WRITING} nv_state_t;
endpackage

// file: design/nv_byte_store.sv
/*
 Byte-wide storage array with one synchronous write port and an asynchronous read port.
 Assumes the caller issues at most one write per cycle.
*/
`timescale 1ns/10ps
module nv_byte_store #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input  wire logic          clock,   // CPU clock
	input  wire logic          ce,      // Clock enable
	input  wire logic          we,      // Write commit
	input  wire logic [AW-1:0] addr,    // Location
	input  wire logic [DW-1:0] wdata,   // Byte to store
	output      logic [DW-1:0] rdata    // Byte at location
);
	// No reset: nonvolatile content is not cleared by reset
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clock) begin
		if (ce && we) begin
			mem[addr] <= wdata;
		end
	end

	// Combinational read so a fetched byte lands in one cycle
	assign rdata = mem[addr];
endmodule

// file: tb/nv_access_control_tb.sv
/*
 Self-checking bench for the nonvolatile store access control block.
 Assumes the package selects and control bit layout; CPU register accesses are modelled
 as one-cycle requests driven at the falling clock edge.
*/
`timescale 1ns/10ps
module nv_access_control_tb;
	import nv_access_pkg::*;
	// Short write time keeps the run brief
	localparam int TICKS = 8;
	logic       clock        = 1'b0;
	logic       nrst         = 1'b0;
	logic       ce           = 1'b1;
	io_req_t    ioReq        = '0;
	logic       rcTick       = 1'b0;
	logic       globalIrqEn  = 1'b0;
	logic       selfProgBusy = 1'b0;
	logic [7:0] ioRdata;
	logic       readyIrq;
	logic       cpuStall;
	logic       writeBusy;
	int         failures     = 0;
	int         comparisons  = 0;
	int         seed         = 32'h8291;
	logic [7:0] irqOn        = 8'h00;
	logic [7:0] got;
	logic [8:0] a;
	logic [7:0] d;

	nv_access_control #(.WRITE_TICKS(TICKS)) nv_access_control_i (
		.clock(clock), .nrst(nrst), .ce(ce), .ioReq(ioReq), .rcTick(rcTick),
		.globalIrqEn(globalIrqEn), .selfProgBusy(selfProgBusy), .ioRdata(ioRdata),
		.readyIrq(readyIrq), .cpuStall(cpuStall), .writeBusy(writeBusy));

	// 25 MHz clock
	always #20 clock = ~clock;

	task automatic end_of_test();
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t %s got %h expected %h", $time, m, g, e);
		end
	endtask

	// Expected control byte from the documented bit layout
	function automatic logic [7:0] ctlByte(input logic irq, input logic busy);
		return {4'h0, irq, 1'b0, busy, 1'b0};
	endfunction

	// Requests stay up until the next task replaces or clears them, so one assignment per step
	task automatic wr(input logic [1:0] s, input logic [7:0] v);
		ioReq = {1'b1, 1'b0, s, v};
		@(negedge clock);
	endtask

	task automatic rd(input logic [1:0] s);
		ioReq = {1'b0, 1'b1, s, 8'h00};
		@(negedge clock);
		got = ioRdata;
	endtask

	task automatic idle(input int n);
		ioReq = '0;
		repeat (n) @(negedge clock);
	endtask

	// Toggling avoids a double assignment of the tick line in one step
	task automatic ticks(input int n);
		repeat (2 * n) begin
			rcTick = ~rcTick;
			@(negedge clock);
		end
	endtask

	task automatic setAddr(input logic [8:0] ad);
		wr(SEL_ADDR_LOW, ad[7:0]);
		wr(SEL_ADDR_HIGH, {7'h0, ad[8]});
	endtask

	// Gap 0 skips the unlock; otherwise the strobe follows gap cycles after it
	task automatic doWrite(input logic [8:0] ad, input logic [7:0] dt, input int gap,
		input logic ok);
		setAddr(ad);
		wr(SEL_BUFFER, dt);
		if (gap > 0) wr(SEL_CONTROL, 8'h04 | irqOn);
		if (gap > 1) idle(gap - 1);
		wr(SEL_CONTROL, 8'h02 | irqOn);
		chk({6'h0, cpuStall, writeBusy}, {6'h0, ok, ok}, "launch");
		idle(1);
		chk({7'h0, cpuStall}, {7'h0, ok}, "write stall");
		idle(1);
		chk({7'h0, cpuStall}, 8'h00, "write stall end");
	endtask

	task automatic rdNow(input logic [7:0] e);
		wr(SEL_CONTROL, 8'h01 | irqOn);
		rd(SEL_BUFFER);
		chk(got, e, "read data");
		chk({7'h0, cpuStall}, 8'h01, "read stall");
		idle(2);
		chk({7'h0, cpuStall}, 8'h01, "read stall late");
		idle(1);
		chk({7'h0, cpuStall}, 8'h00, "read stall end");
	endtask

	// Main sequence
	initial begin
		repeat (4) @(negedge clock);
		nrst = 1'b1;
		rd(SEL_CONTROL);
		chk(got, ctlByte(1'b0, 1'b0), "control reset");
		wr(SEL_ADDR_HIGH, 8'hff);
		rd(SEL_ADDR_HIGH);
		chk(got, 8'h01, "address high");
		// Clock enable low: register writes must not land
		ce = 1'b0;
		wr(SEL_CONTROL, 8'h04);
		wr(SEL_ADDR_HIGH, 8'h00);
		ce = 1'b1;
		rd(SEL_CONTROL);
		chk(got, ctlByte(1'b0, 1'b0), "control frozen");
		rd(SEL_ADDR_HIGH);
		chk(got, 8'h01, "address frozen");
		// Corner addresses first, then random ones, with every unlock gap
		for (int i = 0; i < 6; i++) begin
			{a, d} = 17'($random(seed));
			if (i == 0) a = 9'h000;
			if (i == 1) a = 9'h1ff;
			doWrite(a, d, 1 + i % 4, 1'b1);
			idle(1);
			ticks(TICKS - 1);
			rd(SEL_CONTROL);
			chk(got, ctlByte(irqOn[3], 1'b1), "busy control");
			idle(1);
			ticks(1);
			chk({7'h0, writeBusy}, 8'h00, "write time");
			setAddr(a);
			rd(SEL_ADDR_LOW);
			chk(got, a[7:0], "address low");
			rdNow(d);
		end
		// Refused launches: no unlock, expired unlock, flash busy
		doWrite(9'h055, 8'h3c, 0, 1'b0);
		doWrite(9'h055, 8'h3c, 5, 1'b0);
		selfProgBusy = 1'b1;
		doWrite(9'h055, 8'h3c, 1, 1'b0);
		selfProgBusy = 1'b0;
		// Ready interrupt level follows enable, global bit and busy
		irqOn = 8'h08;
		globalIrqEn = 1'b1;
		wr(SEL_CONTROL, irqOn);
		idle(2);
		chk({7'h0, readyIrq}, 8'h01, "irq on");
		globalIrqEn = 1'b0;
		idle(2);
		chk({7'h0, readyIrq}, 8'h00, "irq global off");
		globalIrqEn = 1'b1;
		doWrite(9'h123, 8'ha5, 2, 1'b1);
		chk({7'h0, readyIrq}, 8'h00, "irq while busy");
		// Mid-write strobe, read and address change must all be ignored
		idle(1);
		ticks(TICKS / 2);
		wr(SEL_CONTROL, 8'h04 | irqOn);
		wr(SEL_CONTROL, 8'h02 | irqOn);
		wr(SEL_ADDR_LOW, 8'h5a);
		wr(SEL_CONTROL, 8'h01 | irqOn);
		idle(1);
		chk({7'h0, cpuStall}, 8'h00, "read while busy");
		ticks(TICKS / 2 - 1);
		chk({7'h0, writeBusy}, 8'h01, "busy kept");
		ticks(1);
		idle(1);
		chk({6'h0, readyIrq, writeBusy}, 8'h02, "write end irq");
		rdNow(8'ha5);
		end_of_test();
	end

	// Watchdog well beyond the expected run
	initial begin
		repeat (4000) @(posedge clock);
		failures++;
		end_of_test();
	end
endmodule
